/* File: rtl/clsu_unit.v */
/*
 * Conditional-load and long-shift execution unit: compare-and-set-A,
 * long left shift/rotate/arithmetic shift, I/O translation load and
 * leave-machine-check.
 * Assumes the decoder holds op_valid for one cycle only while busy is
 * low, and that the register file applies the *_we strobes.
 */
`default_nettype none
`include "clsu_defines.vh"

module clsu_unit #(
    parameter FLT_W  = 32,
    parameter IDX_W  = 6,
    parameter PTE_W  = 16
) (
    input  wire              clk,
    input  wire              sys_rst,
    input  wire              op_valid,
    input  wire [15:0]       op_word,
    input  wire              long_form,
    input  wire              priv_ring,
    input  wire              keys_bit8,
    input  wire [15:0]       a_in,
    input  wire [15:0]       b_in,
    input  wire [FLT_W-1:0]  float_in,
    input  wire [31:0]       operand_addr,
    input  wire              ptw_ack,
    input  wire [PTE_W-1:0]  ptw_entry,
    input  wire              mc_mode_wr,
    input  wire [1:0]        mc_mode_wdata,
    input  wire              mem_parity_err,
    input  wire              mc_flag_clr,
    input  wire [IDX_W-1:0]  tlb_rd_idx,
    output reg               busy_reg,
    output reg               done_reg,
    output reg  [15:0]       a_out_reg,
    output reg  [15:0]       b_out_reg,
    output reg               a_we_reg,
    output reg               b_we_reg,
    output reg               carry_out_reg,
    output reg               carry_we_reg,
    output reg               link_undef_reg,
    output reg               cc_eq_reg,
    output reg               cc_lt_reg,
    output reg               cc_we_reg,
    output reg               cc_undef_reg,
    output reg               int_fault_reg,
    output reg               page_fault_reg,
    output reg               restrict_fault_reg,
    output reg               inhibit_next_reg,
    output reg               ptw_req_reg,
    output reg  [31:0]       ptw_vaddr_reg,
    output reg  [1:0]        mc_mode_reg,
    output reg               mc_flag_reg,
    output reg               mc_check_reg,
    output wire [PTE_W-1:0]  tlb_rd_data_reg,
    output wire              tlb_rd_valid_reg
);

    localparam ST_IDLE  = 2'h0;
    localparam ST_SHIFT = 2'h1;
    localparam ST_WALK  = 2'h2;

    reg  [1:0]       state_reg;
    reg  [31:0]      pair_reg;
    reg  [6:0]       count_reg;
    reg  [1:0]       kind_reg;
    reg              ovf_reg;
    reg  [IDX_W-1:0] tgt_idx_reg;
    reg              par_s1_reg;
    reg              par_s2_reg;
    reg              par_s3_reg;
    reg              par_filt_reg;
    reg              par_filt_next;
    reg              tlb_wr;
    reg              cmp_hit;
    reg              cmp_res;
    reg  [31:0]      cmp_val;
    wire [31:0]      step_pair;
    wire             step_bit;
    wire             step_sign;
    wire [9:0]       sh_sel;
    wire [5:0]       sh_field;
    wire             is_shift;
    wire             par_rise;

    // signed test of a 32-bit value: sel 0 neg,1 nonpos,2 nonzero,3 zero,
    // 4 nonneg,5 pos
    function cmp_eval;
        input [31:0] v;
        input [2:0]  sel;
        reg          neg;
        reg          zero;
        begin
            neg  = v[31];
            zero = (v == 32'h0000_0000);
            case (sel)
                3'h0:    cmp_eval = neg;
                3'h1:    cmp_eval = neg | zero;
                3'h2:    cmp_eval = ~zero;
                3'h3:    cmp_eval = zero;
                3'h4:    cmp_eval = ~neg;
                3'h5:    cmp_eval = ~neg & ~zero;
                default: cmp_eval = 1'b0;
            endcase
        end
    endfunction

    assign sh_sel   = op_word[`CLSU_SH_SEL_HI:`CLSU_SH_SEL_LO];
    assign sh_field = op_word[`CLSU_SH_CNT_HI:`CLSU_SH_CNT_LO];
    assign is_shift = (sh_sel == `CLSU_SH_LOGICAL) |
                      (sh_sel == `CLSU_SH_ARITH) |
                      (sh_sel == `CLSU_SH_ROTATE);

    // compare decode; A is widened by sign so one function serves all
    always @* begin
        cmp_hit = 1'b1;
        cmp_res = 1'b0;
        cmp_val = {{16{a_in[15]}}, a_in};
        case (op_word)
            `CLSU_OP_ACC_NEG:      cmp_res = cmp_eval(cmp_val, 3'h0);
            `CLSU_OP_ACC_NONPOS:   cmp_res = cmp_eval(cmp_val, 3'h1);
            `CLSU_OP_ACC_NONNEG:   cmp_res = cmp_eval(cmp_val, 3'h4);
            `CLSU_OP_ACC_POS:      cmp_res = cmp_eval(cmp_val, 3'h5);
            `CLSU_OP_FLT_NEG: begin
                cmp_val = {float_in[FLT_W-1], 31'h0000_0000};
                cmp_res = cmp_eval(cmp_val, 3'h0);
            end
            `CLSU_OP_FLT_NONZERO: begin
                cmp_val = {31'h0000_0000, |float_in};
                cmp_res = cmp_eval(cmp_val, 3'h2);
            end
            `CLSU_OP_LONG_NEG: begin
                cmp_val = {a_in, b_in};
                cmp_res = cmp_eval(cmp_val, 3'h0);
            end
            `CLSU_OP_LONG_NONPOS: begin
                cmp_val = {a_in, b_in};
                cmp_res = cmp_eval(cmp_val, 3'h1);
            end
            `CLSU_OP_LONG_NONZERO: begin
                cmp_val = {a_in, b_in};
                cmp_res = cmp_eval(cmp_val, 3'h2);
            end
            `CLSU_OP_LONG_ZERO: begin
                cmp_val = {a_in, b_in};
                cmp_res = cmp_eval(cmp_val, 3'h3);
            end
            `CLSU_OP_LONG_NONNEG: begin
                cmp_val = {a_in, b_in};
                cmp_res = cmp_eval(cmp_val, 3'h4);
            end
            `CLSU_OP_LONG_POS: begin
                cmp_val = {a_in, b_in};
                cmp_res = cmp_eval(cmp_val, 3'h5);
            end
            default:               cmp_hit = 1'b0;
        endcase
    end

    clsu_shift_step u_step (
        .pair_in     (pair_reg),
        .kind        (kind_reg),
        .pair_out    (step_pair),
        .bit_out     (step_bit),
        .sign_change (step_sign)
    );

    clsu_io_tlb #(
        .IDX_W  (IDX_W),
        .DATA_W (PTE_W)
    ) u_tlb (
        .clk          (clk),
        .sys_rst      (sys_rst),
        .wr_en        (tlb_wr),
        .wr_idx       (tgt_idx_reg),
        .wr_data      (ptw_entry),
        .rd_idx       (tlb_rd_idx),
        .rd_data_reg  (tlb_rd_data_reg),
        .rd_valid_reg (tlb_rd_valid_reg)
    );

    // translation entry written only on a clean walk answer
    always @* begin
        tlb_wr = (state_reg == ST_WALK) & ptw_ack &
                 ~ptw_entry[`CLSU_PTE_FAULT_BIT];
    end

    // main sequencer; strobes are one-cycle pulses, cleared by default
    always @(posedge clk) begin
        if (sys_rst) begin
            state_reg          <= ST_IDLE;
            pair_reg           <= 32'h0000_0000;
            count_reg          <= 7'h00;
            kind_reg           <= `CLSU_KIND_LOGICAL;
            ovf_reg            <= 1'b0;
            tgt_idx_reg        <= {IDX_W{1'b0}};
            busy_reg           <= 1'b0;
            done_reg           <= 1'b0;
            a_out_reg          <= 16'h0000;
            b_out_reg          <= 16'h0000;
            a_we_reg           <= 1'b0;
            b_we_reg           <= 1'b0;
            carry_out_reg      <= 1'b0;
            carry_we_reg       <= 1'b0;
            link_undef_reg     <= 1'b0;
            cc_eq_reg          <= 1'b0;
            cc_lt_reg          <= 1'b0;
            cc_we_reg          <= 1'b0;
            cc_undef_reg       <= 1'b0;
            int_fault_reg      <= 1'b0;
            page_fault_reg     <= 1'b0;
            restrict_fault_reg <= 1'b0;
            inhibit_next_reg   <= 1'b0;
            ptw_req_reg        <= 1'b0;
            ptw_vaddr_reg      <= 32'h0000_0000;
        end else begin
            done_reg           <= 1'b0;
            a_we_reg           <= 1'b0;
            b_we_reg           <= 1'b0;
            carry_we_reg       <= 1'b0;
            link_undef_reg     <= 1'b0;
            cc_we_reg          <= 1'b0;
            cc_undef_reg       <= 1'b0;
            int_fault_reg      <= 1'b0;
            page_fault_reg     <= 1'b0;
            restrict_fault_reg <= 1'b0;
            inhibit_next_reg   <= 1'b0;
            case (state_reg)
                ST_IDLE: begin
                    if (op_valid && cmp_hit) begin
                        // carry and link strobes stay low here
                        a_out_reg <= {15'h0000, cmp_res};
                        a_we_reg  <= 1'b1;
                        cc_eq_reg <= (cmp_val == 32'h0000_0000);
                        cc_lt_reg <= cmp_val[31];
                        cc_we_reg <= 1'b1;
                        done_reg  <= 1'b1;
                    end else if (op_valid && is_shift) begin
                        pair_reg  <= {a_in, b_in};
                        // negated field; zero wraps to the full count
                        count_reg <= (sh_field == 6'h00) ?
                                     `CLSU_SH_FULL_COUNT :
                                     {1'b0, 6'h00 - sh_field};
                        ovf_reg   <= 1'b0;
                        busy_reg  <= 1'b1;
                        state_reg <= ST_SHIFT;
                        if (sh_sel == `CLSU_SH_ROTATE) begin
                            kind_reg <= `CLSU_KIND_ROTATE;
                        end else if (sh_sel == `CLSU_SH_LOGICAL) begin
                            kind_reg <= `CLSU_KIND_LOGICAL;
                        end else if (long_form) begin
                            kind_reg <= `CLSU_KIND_ARITH32;
                        end else begin
                            kind_reg <= `CLSU_KIND_ARITH31;
                        end
                    end else if (op_valid &&
                                 (op_word == `CLSU_OP_IO_TLB_LOAD ||
                                  op_word == `CLSU_OP_EXIT_MC) &&
                                 !priv_ring) begin
                        restrict_fault_reg <= 1'b1;
                        done_reg           <= 1'b1;
                    end else if (op_valid &&
                                 op_word == `CLSU_OP_IO_TLB_LOAD) begin
                        // segment and word bits of L are dropped
                        tgt_idx_reg   <= b_in[`CLSU_L_PAGE_HI:
                                              `CLSU_L_PAGE_LO];
                        ptw_vaddr_reg <= {16'h0000, operand_addr[15:0]};
                        ptw_req_reg   <= 1'b1;
                        busy_reg      <= 1'b1;
                        state_reg     <= ST_WALK;
                    end else if (op_valid &&
                                 op_word == `CLSU_OP_EXIT_MC) begin
                        inhibit_next_reg <= 1'b1;
                        done_reg         <= 1'b1;
                    end
                end
                ST_SHIFT: begin
                    pair_reg  <= step_pair;
                    count_reg <= count_reg - 7'h01;
                    carry_out_reg <= step_bit;
                    if (kind_reg[1] && step_sign) begin
                        ovf_reg <= 1'b1;
                    end
                    if (count_reg == 7'h01) begin
                        a_out_reg      <= step_pair[31:16];
                        b_out_reg      <= step_pair[15:0];
                        a_we_reg       <= 1'b1;
                        b_we_reg       <= 1'b1;
                        carry_we_reg   <= 1'b1;
                        link_undef_reg <= 1'b1;
                        busy_reg       <= 1'b0;
                        done_reg       <= 1'b1;
                        state_reg      <= ST_IDLE;
                        if (kind_reg[1]) begin
                            // carry is the overflow flag here
                            carry_out_reg <= ovf_reg | step_sign;
                            cc_undef_reg  <= 1'b1;
                            int_fault_reg <= (ovf_reg | step_sign) &
                                             keys_bit8;
                        end
                    end
                end
                ST_WALK: begin
                    if (ptw_ack) begin
                        ptw_req_reg    <= 1'b0;
                        page_fault_reg <=
                            ptw_entry[`CLSU_PTE_FAULT_BIT];
                        link_undef_reg <= 1'b1;
                        cc_undef_reg   <= 1'b1;
                        busy_reg       <= 1'b0;
                        done_reg       <= 1'b1;
                        state_reg      <= ST_IDLE;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                    busy_reg  <= 1'b0;
                end
            endcase
        end
    end

    // parity pin: three stages; a change counts once stages 2 and 3 agree
    always @* begin
        par_filt_next = (par_s2_reg == par_s3_reg) ? par_s3_reg
                                                   : par_filt_reg;
    end
    assign par_rise = par_filt_next & ~par_filt_reg;

    always @(posedge clk) begin
        if (sys_rst) begin
            par_s1_reg   <= 1'b0;
            par_s2_reg   <= 1'b0;
            par_s3_reg   <= 1'b0;
            par_filt_reg <= 1'b0;
        end else begin
            par_s1_reg   <= mem_parity_err;
            par_s2_reg   <= par_s1_reg;
            par_s3_reg   <= par_s2_reg;
            par_filt_reg <= par_filt_next;
        end
    end

    // check mode, flag and check pulse; a new error beats a clear
    always @(posedge clk) begin
        if (sys_rst) begin
            mc_mode_reg  <= `CLSU_MC_MODE_OFF;
            mc_flag_reg  <= 1'b0;
            mc_check_reg <= 1'b0;
        end else begin
            if (state_reg == ST_IDLE && op_valid && priv_ring &&
                op_word == `CLSU_OP_EXIT_MC) begin
                mc_mode_reg <= `CLSU_MC_MODE_OFF;
            end else if (mc_mode_wr) begin
                mc_mode_reg <= mc_mode_wdata;
            end
            if (par_rise) begin
                mc_flag_reg <= 1'b1;
            end else if (mc_flag_clr) begin
                mc_flag_reg <= 1'b0;
            end
            // with mode off the error never raises a
            mc_check_reg <= par_rise &&
                            (mc_mode_reg != `CLSU_MC_MODE_OFF);
        end
    end

endmodule // clsu_unit

`default_nettype wire

/* File: rtl/clsu_defines.vh */
/*
 * Constants for the conditional-load and long-shift unit: opcodes,
 * field positions, step counts, shift kinds and the check mode value.
 * Assumes the decoder presents the whole 16-bit instruction word.
 */
`ifndef CLSU_DEFINES_VH
`define CLSU_DEFINES_VH

// full-word opcodes of the compare-and-set-A group
`define CLSU_OP_ACC_NEG      16'hC108
`define CLSU_OP_ACC_NONPOS   16'hC109
`define CLSU_OP_ACC_NONNEG   16'hC10C
`define CLSU_OP_ACC_POS      16'hC10D
`define CLSU_OP_FLT_NEG      16'hC248
`define CLSU_OP_FLT_NONZERO  16'hC24A
`define CLSU_OP_LONG_NEG     16'hC348
`define CLSU_OP_LONG_NONPOS  16'hC349
`define CLSU_OP_LONG_NONZERO 16'hC34A
`define CLSU_OP_LONG_ZERO    16'hC34B
`define CLSU_OP_LONG_NONNEG  16'hC34C
`define CLSU_OP_LONG_POS     16'hC34D
// privileged single-word opcodes
`define CLSU_OP_IO_TLB_LOAD  16'h0024
`define CLSU_OP_EXIT_MC      16'h0141

// long shift group: upper ten bits select, low six hold the count
`define CLSU_SH_SEL_HI       15
`define CLSU_SH_SEL_LO       6
`define CLSU_SH_LOGICAL      10'h108
`define CLSU_SH_ARITH        10'h109
`define CLSU_SH_ROTATE       10'h10A
`define CLSU_SH_CNT_HI       5
`define CLSU_SH_CNT_LO       0
`define CLSU_SH_FULL_COUNT   7'h40

// shift kinds handed to the step module
`define CLSU_KIND_LOGICAL    2'h0
`define CLSU_KIND_ROTATE     2'h1
`define CLSU_KIND_ARITH32    2'h2
`define CLSU_KIND_ARITH31    2'h3

// page table entry: fault flag is the top bit
`define CLSU_PTE_FAULT_BIT   15
// target page number field of L (word bits and segment ignored)
`define CLSU_L_PAGE_HI       15
`define CLSU_L_PAGE_LO       10

// machine check mode field reset / cleared value
`define CLSU_MC_MODE_OFF     2'h0

`endif

/* File: rtl/clsu_shift_step.v */
/*
 * One step of the double-register left shift/rotate engine.
 * Purely combinational; the caller registers the result each cycle.
 * Assumes A sits in bits 31:16 and B in bits 15:0 of the pair.
 */
`default_nettype none
`include "clsu_defines.vh"

module clsu_shift_step (
    input  wire [31:0] pair_in,
    input  wire [1:0]  kind,
    output reg  [31:0] pair_out,
    output reg         bit_out,
    output reg         sign_change
);

    // the 31-bit form keeps B bit 1 (index 15) out of the shift
    always @* begin
        pair_out    = {pair_in[30:0], 1'b0};
        bit_out     = pair_in[31];
        sign_change = pair_in[31] ^ pair_in[30];
        case (kind)
            `CLSU_KIND_ROTATE: begin
                pair_out = {pair_in[30:0], pair_in[31]};
            end
            `CLSU_KIND_ARITH31: begin
                pair_out = {pair_in[30:16], pair_in[14], pair_in[15],
                            pair_in[13:0], 1'b0};
            end
            default: begin
                pair_out = {pair_in[30:0], 1'b0};
            end
        endcase
    end

endmodule // clsu_shift_step

`default_nettype wire

/* File: rtl/clsu_io_tlb.v */
/*
 * I/O translation buffer storage: flip-flop array, one write port
 * and one registered read port.
 * Assumes writes come only from the unit's translation-load sequence.
 */
`default_nettype none

module clsu_io_tlb #(
    parameter IDX_W  = 6,
    parameter DATA_W = 16
) (
    input  wire              clk,
    input  wire              sys_rst,
    input  wire              wr_en,
    input  wire [IDX_W-1:0]  wr_idx,
    input  wire [DATA_W-1:0] wr_data,
    input  wire [IDX_W-1:0]  rd_idx,
    output reg  [DATA_W-1:0] rd_data_reg,
    output reg               rd_valid_reg
);

    localparam DEPTH = 1 << IDX_W;

    reg [DATA_W-1:0] entry_reg [0:DEPTH-1];
    reg [DEPTH-1:0]  valid_reg;

    // storage and valid bits; reset clears only the valid bits
    always @(posedge clk) begin
        if (wr_en) begin
            entry_reg[wr_idx] <= wr_data;
        end
        if (sys_rst) begin
            valid_reg <= {DEPTH{1'b0}};
        end else if (wr_en) begin
            valid_reg[wr_idx] <= 1'b1;
        end
    end

    // registered read keeps the output straight from a flip-flop
    always @(posedge clk) begin
        if (sys_rst) begin
            rd_data_reg  <= {DATA_W{1'b0}};
            rd_valid_reg <= 1'b0;
        end else begin
            rd_data_reg  <= entry_reg[rd_idx];
            rd_valid_reg <= valid_reg[rd_idx];
        end
    end

endmodule // clsu_io_tlb

`default_nettype wire

/* File: dv/clsu_properties.sv */
/* Port-level timing checks on the conditional-load and shift unit.
   Assumes it is bound onto clsu_unit: one clock, synchronous reset. */
`default_nettype none
`include "clsu_defines.vh"
module clsu_properties (
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic        op_valid,
    input wire logic [15:0] op_word,
    input wire logic        priv_ring,
    input wire logic        ptw_ack,
    input wire logic        busy_reg,
    input wire logic        done_reg,
    input wire logic        a_we_reg,
    input wire logic        cc_we_reg,
    input wire logic        carry_we_reg,
    input wire logic        carry_out_reg,
    input wire logic        link_undef_reg,
    input wire logic        int_fault_reg,
    input wire logic        restrict_fault_reg,
    input wire logic        inhibit_next_reg,
    input wire logic        ptw_req_reg,
    input wire logic [1:0]  mc_mode_reg
);
    // requests only count while idle; busy ones are dropped
    wire go  = op_valid && !busy_reg;
    wire xmc = go && op_word == `CLSU_OP_EXIT_MC;
    wire tlb = go && op_word == `CLSU_OP_IO_TLB_LOAD;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    a_cmp_writes: assert property (
        go && op_word == `CLSU_OP_ACC_NEG |=> a_we_reg && cc_we_reg && done_reg)
        else $error("compare did not write back");
    a_cmp_keeps_flags: assert property (
        cc_we_reg |-> !carry_we_reg && !link_undef_reg)
        else $error("compare touched carry or link");
    a_shift_link_undef: assert property (
        carry_we_reg |-> link_undef_reg && !cc_we_reg)
        else $error("shift flag strobes wrong");
    a_one_step_shift: assert property (
        go && op_word == {`CLSU_SH_LOGICAL, 6'h3F} |=>
        busy_reg ##1 done_reg && !busy_reg)
        else $error("single-step shift timing wrong");
    a_fault_sets_carry: assert property (
        int_fault_reg |-> carry_we_reg && carry_out_reg)
        else $error("fault without carry set");
    a_exit_clears_mode: assert property (
        xmc && priv_ring |=> inhibit_next_reg && mc_mode_reg == 2'h0)
        else $error("exit did not clear mode");
    a_exit_refused: assert property (
        xmc && !priv_ring |=> restrict_fault_reg && !inhibit_next_reg)
        else $error("unprivileged exit not refused");
    a_tlb_refused: assert property (
        tlb && !priv_ring |=> restrict_fault_reg && !ptw_req_reg)
        else $error("unprivileged load not refused");
    a_ptw_holds: assert property (
        ptw_req_reg && !ptw_ack |=> ptw_req_reg)
        else $error("walk request dropped early");
    cover property (int_fault_reg);
    cover property (inhibit_next_reg);
    cover property (restrict_fault_reg);
endmodule // clsu_properties
bind clsu_unit clsu_properties clsu_properties_inst (.*);
`default_nettype wire

/* File: dv/clsu_unit_tb_top.sv */
/* Directed testbench for clsu_unit: compare, shift, load and exit ops.
   Assumes the design ignores requests while busy; acks walks promptly. */
`default_nettype none
`include "clsu_defines.vh"
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
    n_mismatch++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module clsu_unit_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk, sys_rst, op_valid, long_form, priv_ring, keys_bit8;
    logic        ptw_ack, mc_mode_wr, mem_parity_err, mc_flag_clr;
    logic [15:0] op_word, a_in, b_in, ptw_entry;
    logic [31:0] float_in, operand_addr;
    logic [1:0]  mc_mode_wdata;
    logic [5:0]  tlb_rd_idx;
    wire         busy_reg, done_reg, a_we_reg, b_we_reg, carry_out_reg;
    wire         carry_we_reg, link_undef_reg, cc_eq_reg, cc_lt_reg;
    wire         cc_we_reg, cc_undef_reg, int_fault_reg, page_fault_reg;
    wire         restrict_fault_reg, inhibit_next_reg, ptw_req_reg;
    wire         mc_flag_reg, mc_check_reg, tlb_rd_valid_reg;
    wire [15:0]  a_out_reg, b_out_reg, tlb_rd_data_reg;
    wire [31:0]  ptw_vaddr_reg;
    wire [1:0]   mc_mode_reg;
    int          n_mismatch, total_checks, k, seen;
    clsu_unit clsu_unit_inst (.*);
    // free-running 20 MHz clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // one instruction; walk answered one cycle after request seen
    task automatic run(input [15:0] op, a, b, input [31:0] f);
        int i;
        logic ack_nx;
        @(posedge clk);
        op_valid <= 1'b1;
        op_word <= op;
        a_in <= a;
        b_in <= b;
        float_in <= f;
        #1;
        for (i = 0; i < 200 && done_reg !== 1'b1; i++) begin
            // decide the answer on settled values, not at the edge
            ack_nx = ptw_req_reg === 1'b1 && ptw_ack !== 1'b1;
            @(posedge clk);
            op_valid <= 1'b0;
            ptw_ack <= ack_nx;
            #1;
        end
        if (done_reg !== 1'b1) begin
            n_mismatch++;
            conclude();
        end
    endtask
    task automatic tcmp(input [15:0] op, a, b, input [31:0] f, input e);
        logic [1:0] ecc;
        run(op, a, b, f);
        // eq on a zero tested value, lt on its sign; float forms skipped
        ecc = {(op[9] ? {a, b} == 32'h0 : a == 16'h0), a[15]};
        `CHK("a_out", {15'h0, e}, a_out_reg)
        `CHK("flags", 1'b1, cc_we_reg && !carry_we_reg)
        if (op[8]) `CHK("cc", ecc, {cc_eq_reg, cc_lt_reg})
    endtask
    task automatic tsh(input [15:0] op, a, b, ea, eb, input ec);
        run(op, a, b, 32'h0);
        `CHK("pair", {ea, eb}, {a_out_reg, b_out_reg})
        `CHK("carry", ec, carry_out_reg)
        `CHK("strobes", 1'b1, link_undef_reg && a_we_reg && !cc_we_reg)
        `CHK("b_we", 1'b1, b_we_reg)
    endtask
    initial begin
        {op_valid, long_form, priv_ring, keys_bit8, ptw_ack} = '0;
        {mc_mode_wr, mem_parity_err, mc_flag_clr, mc_mode_wdata} = '0;
        {op_word, a_in, b_in, ptw_entry, float_in, operand_addr} = '0;
        tlb_rd_idx = '0;
        sys_rst = 1'b1;
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        tcmp(`CLSU_OP_ACC_NEG, 16'h8000, 16'h0, 32'h0, 1'b1);
        tcmp(`CLSU_OP_ACC_NEG, 16'h0000, 16'h0, 32'h0, 1'b0);
        tcmp(`CLSU_OP_ACC_NONPOS, 16'h0, 16'h0, 32'h0, 1'b1);
        tcmp(`CLSU_OP_ACC_NONPOS, 16'h1, 16'h0, 32'h0, 1'b0);
        tcmp(`CLSU_OP_ACC_NONNEG, 16'h0, 16'h0, 32'h0, 1'b1);
        tcmp(`CLSU_OP_ACC_NONNEG, 16'hFFFF, 16'h0, 32'h0, 1'b0);
        tcmp(`CLSU_OP_ACC_POS, 16'h1, 16'h0, 32'h0, 1'b1);
        tcmp(`CLSU_OP_ACC_POS, 16'h0, 16'hFFFF, 32'h0, 1'b0);
        tcmp(`CLSU_OP_FLT_NEG, 16'h1, 16'h0, 32'h8000_0000, 1'b1);
        tcmp(`CLSU_OP_FLT_NONZERO, 16'h1, 16'h0, 32'h0, 1'b0);
        tcmp(`CLSU_OP_FLT_NONZERO, 16'h0, 16'h0, 32'h100, 1'b1);
        tcmp(`CLSU_OP_LONG_NEG, 16'h8000, 16'h0, 32'h0, 1'b1);
        tcmp(`CLSU_OP_LONG_NONPOS, 16'h0, 16'h0, 32'h0, 1'b1);
        tcmp(`CLSU_OP_LONG_POS, 16'h0, 16'h1, 32'h0, 1'b1);
        tcmp(`CLSU_OP_LONG_NONZERO, 16'h0, 16'h1, 32'h0, 1'b1);
        tcmp(`CLSU_OP_LONG_ZERO, 16'h0, 16'h1, 32'h0, 1'b0);
        tcmp(`CLSU_OP_LONG_NONNEG, 16'h0, 16'h0, 32'h0, 1'b1);
        tsh({`CLSU_SH_LOGICAL, 6'h3F}, 16'h8001, 16'h8000, 16'h0003,
            16'h0000, 1'b1);
        tsh({`CLSU_SH_LOGICAL, 6'h00}, 16'hFFFF, 16'hFFFF, 16'h0, 16'h0,
            1'b0);
        tsh({`CLSU_SH_ROTATE, 6'h3E}, 16'hC000, 16'h0001, 16'h0000,
            16'h0007, 1'b1);
        long_form <= 1'b1;
        keys_bit8 <= 1'b1;
        tsh({`CLSU_SH_ARITH, 6'h3F}, 16'h4000, 16'h0, 16'h8000, 16'h0,
            1'b1);
        `CHK("int_fault", 1'b1, int_fault_reg)
        tsh({`CLSU_SH_ARITH, 6'h3F}, 16'h1, 16'h0, 16'h2, 16'h0, 1'b0);
        keys_bit8 <= 1'b0;
        tsh({`CLSU_SH_ARITH, 6'h3F}, 16'h4000, 16'h0, 16'h8000, 16'h0,
            1'b1);
        `CHK("int_fault", 1'b0, int_fault_reg)
        long_form <= 1'b0;
        tsh({`CLSU_SH_ARITH, 6'h3F}, 16'h0, 16'hC000, 16'h1, 16'h8000,
            1'b0);
        priv_ring <= 1'b1;
        operand_addr <= 32'h0001_2345;
        ptw_entry <= 16'h0ABC;
        run(`CLSU_OP_IO_TLB_LOAD, 16'h1234, 16'hFC00, 32'h0);
        `CHK("vaddr", 32'h0000_2345, ptw_vaddr_reg)
        `CHK("undef", 2'b01, {page_fault_reg, cc_undef_reg})
        tlb_rd_idx <= 6'h3F;
        repeat (2) @(posedge clk);
        #1;
        `CHK("tlb", 17'h10ABC, {tlb_rd_valid_reg, tlb_rd_data_reg})
        ptw_entry <= 16'h8000;
        run(`CLSU_OP_IO_TLB_LOAD, 16'h0, 16'h0400, 32'h0);
        `CHK("page_fault", 1'b1, page_fault_reg)
        mc_mode_wr <= 1'b1;
        mc_mode_wdata <= 2'h3;
        priv_ring <= 1'b0;
        run(`CLSU_OP_IO_TLB_LOAD, 16'h0, 16'h0, 32'h0);
        mc_mode_wr <= 1'b0;
        `CHK("restrict", 1'b1, restrict_fault_reg)
        run(`CLSU_OP_EXIT_MC, 16'h0, 16'h0, 32'h0);
        `CHK("mode_kept", 3'h7, {restrict_fault_reg, mc_mode_reg})
        priv_ring <= 1'b1;
        run(`CLSU_OP_EXIT_MC, 16'h0, 16'h0, 32'h0);
        `CHK("exit", 3'h4, {inhibit_next_reg, mc_mode_reg})
        // parity rise with check mode off: flag only, never a check
        mem_parity_err <= 1'b1;
        seen = 0;
        for (k = 0; k < 10; k++) begin
            @(posedge clk);
            #1;
            if (mc_check_reg !== 1'b0) seen = 1;
        end
        `CHK("mc_flag", 2'b10, {mc_flag_reg, seen[0]})
        // clear the flag, arm check mode; the next rise must check once
        mc_flag_clr <= 1'b1;
        mc_mode_wr <= 1'b1;
        mem_parity_err <= 1'b0;
        repeat (6) @(posedge clk);
        {mc_flag_clr, mc_mode_wr} <= 2'b00;
        #1;
        `CHK("mc_clr", 1'b0, mc_flag_reg)
        mem_parity_err <= 1'b1;
        seen = 0;
        for (k = 0; k < 10; k++) begin
            @(posedge clk);
            #1;
            seen += mc_check_reg === 1'b1;
        end
        `CHK("mc_check", 3'h5, {mc_flag_reg, seen[1:0]})
        conclude();
    end
endmodule // clsu_unit_tb_top
`default_nettype wire
